// *** hw/stpg_pkg.sv ***
package stpg_pkg;

    // ------------------------------------------------------------
    // Counter and word widths
    // ------------------------------------------------------------
    localparam int H_W = 13;
    localparam int V_W = 11;
    localparam int W_W = 10;

    // ------------------------------------------------------------
    // Standard select codes
    // ------------------------------------------------------------
    localparam logic [2:0] STD_HD = 3'h1;
    localparam logic [2:0] STD_3GB = 3'h2;
    localparam logic [2:0] STD_3GA = 3'h3;

    // ------------------------------------------------------------
    // Transport format codes
    // ------------------------------------------------------------
    localparam logic [3:0] FMT_525I = 4'h0;
    localparam logic [3:0] FMT_625I = 4'h1;
    localparam logic [3:0] FMT_1080I60 = 4'h4;
    localparam logic [3:0] FMT_1080I50 = 4'h5;
    localparam logic [3:0] FMT_1080P24 = 4'h6;
    localparam logic [3:0] FMT_720P60 = 4'h7;
    localparam logic [3:0] FMT_720P50 = 4'h8;
    localparam logic [3:0] FMT_720P30 = 4'h9;
    localparam logic [3:0] FMT_720P25 = 4'hA;
    localparam logic [3:0] FMT_720P24 = 4'hB;
    localparam logic [3:0] FMT_1080P30 = 4'hC;
    localparam logic [3:0] FMT_1080P25 = 4'hD;
    localparam logic [3:0] FMT_1080SF24 = 4'hE;

    // ------------------------------------------------------------
    // Video levels and bar width shift
    // ------------------------------------------------------------
    localparam logic [W_W-1:0] Y_BLACK = 10'h040;
    localparam logic [W_W-1:0] C_ZERO = 10'h200;
    localparam logic [W_W-1:0] PATHO_Y1 = 10'h198;
    localparam logic [W_W-1:0] PATHO_C1 = 10'h300;
    localparam logic [W_W-1:0] PATHO_Y2 = 10'h110;
    localparam logic [W_W-1:0] PATHO_C2 = 10'h200;
    localparam int BAR_SHIFT = 3;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } stpg_state_e;

    typedef struct packed {
        logic [H_W-1:0] h_total;
        logic [H_W-1:0] h_active;
        logic [V_W-1:0] v_total;
        logic [V_W-1:0] v_active;
        logic interlaced;
        logic frac_ok;
    } stpg_timing_s;

    // Raster geometry per format code; reserved codes fall back to 525i
    function automatic stpg_timing_s stpg_fmt_timing(input logic [3:0] code);
        stpg_timing_s t;
        t = '{13'h035A, 13'h02D0, 11'h20D, 11'h1E6, 1'b1, 1'b0};
        case (code)
            FMT_625I: t = '{13'h0360, 13'h02D0, 11'h271, 11'h240, 1'b1, 1'b0};
            FMT_1080I60: t = '{13'h0898, 13'h0780, 11'h465, 11'h438, 1'b1, 1'b1};
            FMT_1080I50: t = '{13'h0A50, 13'h0780, 11'h465, 11'h438, 1'b1, 1'b0};
            FMT_1080P24: t = '{13'h0ABE, 13'h0780, 11'h465, 11'h438, 1'b0, 1'b1};
            FMT_720P60: t = '{13'h0672, 13'h0500, 11'h2EE, 11'h2D0, 1'b0, 1'b1};
            FMT_720P50: t = '{13'h07BC, 13'h0500, 11'h2EE, 11'h2D0, 1'b0, 1'b0};
            FMT_720P30: t = '{13'h0CE4, 13'h0500, 11'h2EE, 11'h2D0, 1'b0, 1'b1};
            FMT_720P25: t = '{13'h0F78, 13'h0500, 11'h2EE, 11'h2D0, 1'b0, 1'b0};
            FMT_720P24: t = '{13'h101D, 13'h0500, 11'h2EE, 11'h2D0, 1'b0, 1'b1};
            FMT_1080P30: t = '{13'h0898, 13'h0780, 11'h465, 11'h438, 1'b0, 1'b1};
            FMT_1080P25: t = '{13'h0A50, 13'h0780, 11'h465, 11'h438, 1'b0, 1'b0};
            FMT_1080SF24: t = '{13'h0ABE, 13'h0780, 11'h465, 11'h438, 1'b1, 1'b1};
            default: t = '{13'h035A, 13'h02D0, 11'h20D, 11'h1E6, 1'b1, 1'b0};
        endcase
        return t;
    endfunction

endpackage

// *** hw/stpg_bar_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface stpg_bar_if;
    logic [2:0] idx;
    logic amp100;
    logic [9:0] y;
    logic [9:0] cb;
    logic [9:0] cr;
    modport req (output idx, output amp100, input y, input cb, input cr);
    modport rsp (input idx, input amp100, output y, output cb, output cr);
endinterface
`default_nettype wire

// *** hw/stpg_bar_lut.sv ***
`timescale 1ns/1ps
`default_nettype none
module stpg_bar_lut (
    stpg_bar_if.rsp bar // Bar index in, colour out
);
    // ------------------------------------------------------------
    // Colour table: white, yellow, cyan, green, magenta, red, blue, black
    // ------------------------------------------------------------
    function automatic logic [29:0] stpg_bar_color(input logic amp100, input logic [2:0] idx);
        logic [29:0] v;
        v = {10'h040, 10'h200, 10'h200};
        case ({amp100, idx})
            4'h0: v = {10'h2D1, 10'h200, 10'h200};
            4'h1: v = {10'h2A2, 10'h0B0, 10'h21F};
            4'h2: v = {10'h245, 10'h24D, 10'h0B0};
            4'h3: v = {10'h216, 10'h0FD, 10'h0CF};
            4'h4: v = {10'h0FB, 10'h303, 10'h331};
            4'h5: v = {10'h0CC, 10'h1B3, 10'h350};
            4'h6: v = {10'h06F, 10'h350, 10'h1E1};
            4'h8: v = {10'h3AC, 10'h200, 10'h200};
            4'h9: v = {10'h36D, 10'h040, 10'h249};
            4'hA: v = {10'h2F1, 10'h267, 10'h040};
            4'hB: v = {10'h2B2, 10'h0A7, 10'h089};
            4'hC: v = {10'h13A, 10'h359, 10'h377};
            4'hD: v = {10'h0FB, 10'h199, 10'h3C0};
            4'hE: v = {10'h07F, 10'h3C0, 10'h1B7};
            default: v = {10'h040, 10'h200, 10'h200};
        endcase
        return v;
    endfunction

    assign {bar.y, bar.cb, bar.cr} = stpg_bar_color(bar.amp100, bar.idx);

    // Only checked on the white bar, so an undriven index before reset stays quiet
    always_comb begin
        if (bar.idx == 3'h0) begin
            white_amp_a: assert (bar.y == (bar.amp100 ? 10'h3AC : 10'h2D1))
                else $error("white bar level does not follow amplitude select");
        end
    end
endmodule
`default_nettype wire

// *** hw/stpg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module stpg_top
    import stpg_pkg::*;
(
    input wire logic ref_clk, // Transmit parallel clock
    input wire logic nrst, // Synchronous reset, active low
    input wire logic ce, // Clock enable, freezes all state
    input wire logic [2:0] std_select, // Video standard
    input wire logic [3:0] format_select, // Transport format
    input wire logic dual_link_map_enable, // Dual-link mapping request
    input wire logic rate_frac_select, // High for 1/1.001 rate
    input wire logic bar_amplitude_select, // High for 100% bars
    input wire logic patho_select, // Pathological pattern
    input wire logic blank_select, // Black picture
    input wire logic no_color_select, // Zero chroma bars
    input wire logic seg_frame_select, // Segmented frame output
    output logic [9:0] y_word, // Luma word
    output logic [9:0] c_word, // Chroma word
    output logic h_blank, // Horizontal blanking
    output logic v_blank, // Vertical blanking
    output logic field_id, // Second field or segment
    output logic sof, // First sample of frame
    output logic [10:0] line_num, // Frame line counter
    output logic frac_rate, // Fractional clock request
    output logic seg_frame, // Segmented frame active
    output logic dl_active, // Dual-link mapping active
    output logic std_hd, // HD standard decoded
    output logic std_3gb, // 3G level B decoded
    output logic std_3ga // 3G level A decoded
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        stpg_state_e state;
        logic [3:0] cur_fmt;
        logic [H_W-1:0] h_cnt;
        logic [V_W-1:0] v_cnt;
        logic [H_W-1:0] bar_cnt;
        logic [2:0] bar_idx;
        logic [W_W-1:0] y_word;
        logic [W_W-1:0] c_word;
        logic h_blank;
        logic v_blank;
        logic field_id;
        logic sof;
        logic frac_rate;
        logic seg_frame;
        logic dl_active;
        logic std_hd;
        logic std_3gb;
        logic std_3ga;
    } stpg_regs_s;

    stpg_regs_s r_ff;
    stpg_regs_s nxt_r;
    stpg_timing_s tim;
    stpg_bar_if bar ();
    logic [V_W-1:0] v_half;
    logic [V_W-1:0] v_in_fld;
    logic [V_W-1:0] v_act_fld;
    logic second_fld;
    logic pix_act;
    logic fmt_chg;

    stpg_bar_lut u_bar_lut (
        .bar(bar)
    );

    assign bar.idx = r_ff.bar_idx;
    assign bar.amp100 = bar_amplitude_select;

    // ------------------------------------------------------------
    // Raster position decode
    // ------------------------------------------------------------
    // format code selects geometry
    assign tim = stpg_fmt_timing(r_ff.cur_fmt);
    assign v_half = tim.v_total >> 1;
    assign second_fld = tim.interlaced && (r_ff.v_cnt >= v_half);
    assign v_in_fld = second_fld ? (r_ff.v_cnt - v_half) : r_ff.v_cnt;
    assign v_act_fld = tim.interlaced ? (tim.v_active >> 1) : tim.v_active;
    assign pix_act = (r_ff.h_cnt < tim.h_active) && (v_in_fld < v_act_fld);
    assign fmt_chg = (format_select != r_ff.cur_fmt);

    always_comb begin
        nxt_r = r_ff;
        nxt_r.sof = 1'b0;
        nxt_r.std_hd = (std_select == STD_HD);
        nxt_r.std_3gb = (std_select == STD_3GB);
        nxt_r.std_3ga = (std_select == STD_3GA);
        // mapping only honoured for HD or 3Gb
        nxt_r.dl_active = dual_link_map_enable && (std_select == STD_HD || std_select == STD_3GB);
        nxt_r.frac_rate = rate_frac_select && tim.frac_ok;
        nxt_r.seg_frame = seg_frame_select && (r_ff.cur_fmt == FMT_1080I60 || r_ff.cur_fmt == FMT_1080I50);
        case (r_ff.state)
            ST_LOAD: begin
                nxt_r.cur_fmt = format_select;
                nxt_r.h_cnt = '0;
                nxt_r.v_cnt = '0;
                nxt_r.bar_cnt = '0;
                nxt_r.bar_idx = '0;
                nxt_r.y_word = Y_BLACK;
                nxt_r.c_word = C_ZERO;
                nxt_r.state = ST_RUN;
            end
            ST_RUN: begin
                if (fmt_chg) begin
                    nxt_r.state = ST_LOAD;
                end else begin
                    if (r_ff.h_cnt == tim.h_total - 13'h0001) begin
                        nxt_r.h_cnt = '0;
                        nxt_r.bar_cnt = '0;
                        nxt_r.bar_idx = '0;
                        if (r_ff.v_cnt == tim.v_total - 11'h001) begin
                            nxt_r.v_cnt = '0;
                        end else begin
                            nxt_r.v_cnt = r_ff.v_cnt + 11'h001;
                        end
                    end else begin
                        nxt_r.h_cnt = r_ff.h_cnt + 13'h0001;
                        if (r_ff.bar_cnt == (tim.h_active >> BAR_SHIFT) - 13'h0001) begin
                            nxt_r.bar_cnt = '0;
                            nxt_r.bar_idx = r_ff.bar_idx + 3'h1;
                        end else begin
                            nxt_r.bar_cnt = r_ff.bar_cnt + 13'h0001;
                        end
                    end
                    nxt_r.sof = (r_ff.h_cnt == '0) && (r_ff.v_cnt == '0);
                    nxt_r.h_blank = (r_ff.h_cnt >= tim.h_active);
                    nxt_r.v_blank = (v_in_fld >= v_act_fld);
                    nxt_r.field_id = second_fld;
                    if (!pix_act) begin
                        nxt_r.y_word = Y_BLACK;
                        nxt_r.c_word = C_ZERO;
                    end else if (blank_select) begin
                        nxt_r.y_word = Y_BLACK;
                        nxt_r.c_word = C_ZERO;
                    end else if (patho_select) begin
                        nxt_r.y_word = (v_in_fld < (v_act_fld >> 1)) ? PATHO_Y1 : PATHO_Y2;
                        nxt_r.c_word = (v_in_fld < (v_act_fld >> 1)) ? PATHO_C1 : PATHO_C2;
                    end else begin
                        nxt_r.y_word = bar.y;
                        if (no_color_select) begin
                            nxt_r.c_word = C_ZERO;
                        end else begin
                            nxt_r.c_word = r_ff.h_cnt[0] ? bar.cr : bar.cb;
                        end
                    end
                end
            end
            default: begin
                nxt_r.state = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            r_ff <= '{state: ST_LOAD, y_word: Y_BLACK, c_word: C_ZERO, default: '0};
        end else if (ce) begin
            r_ff <= nxt_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign y_word = r_ff.y_word;
    assign c_word = r_ff.c_word;
    assign h_blank = r_ff.h_blank;
    assign v_blank = r_ff.v_blank;
    assign field_id = r_ff.field_id;
    assign sof = r_ff.sof;
    assign line_num = r_ff.v_cnt;
    assign frac_rate = r_ff.frac_rate;
    assign seg_frame = r_ff.seg_frame;
    assign dl_active = r_ff.dl_active;
    assign std_hd = r_ff.std_hd;
    assign std_3gb = r_ff.std_3gb;
    assign std_3ga = r_ff.std_3ga;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb_chk @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    int_rate_a: assert property (ce && !rate_frac_select |=> !frac_rate)
        else $error("integer rate selected but fractional request raised");
    no_frac_a: assert property (ce && (r_ff.cur_fmt == FMT_720P50 || r_ff.cur_fmt == FMT_625I) |=> !frac_rate)
        else $error("fractional request on format without fractional variant");
    patho_out_a: assert property (ce && r_ff.state == ST_RUN && !fmt_chg && pix_act && patho_select && !blank_select
        |=> y_word == PATHO_Y1 || y_word == PATHO_Y2)
        else $error("pathological level missing");
    black_out_a: assert property (ce && r_ff.state == ST_RUN && !fmt_chg && blank_select
        |=> y_word == Y_BLACK && c_word == C_ZERO)
        else $error("black picture not produced");
    no_chroma_a: assert property (ce && r_ff.state == ST_RUN && !fmt_chg && no_color_select && !patho_select
        |=> c_word == C_ZERO)
        else $error("chroma present with colourless bars");
    seg_frame_a: assert property (ce && seg_frame_select && r_ff.cur_fmt == FMT_1080I50 |=> seg_frame)
        else $error("segmented frame not flagged");
    std_dec_a: assert property (ce && std_select == STD_3GA |=> std_3ga && !std_hd && !std_3gb)
        else $error("standard decode wrong");
    line_wrap_a: assert property (ce && r_ff.state == ST_RUN && !fmt_chg && r_ff.h_cnt == tim.h_total - 13'h0001
        |=> r_ff.h_cnt == '0)
        else $error("line length wrong");
    fmt_load_a: assert property (ce && r_ff.state == ST_RUN && fmt_chg ##1 ce |=> r_ff.cur_fmt == $past(format_select))
        else $error("format change not loaded");
    dl_gate_a: assert property (ce && std_select == STD_3GA |=> !dl_active)
        else $error("dual-link mapping active on 3Ga");
endmodule
`default_nettype wire

// *** hw/_end.sv ***
`timescale 1ns/1ps

// *** tb/stpg_sink.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Receiving end: measures one whole line of the stream
// ------------------------------------------------------------
module stpg_sink (
    input wire logic ref_clk, // Parallel clock
    input wire logic ce, // Sample strobe
    input wire logic arm, // Start one measurement
    input wire logic [12:0] probe, // Active sample to capture
    input wire logic [9:0] y_word, // Luma in
    input wire logic [9:0] c_word, // Chroma in
    input wire logic h_blank, // Horizontal blanking in
    output logic done, // Measurement ready pulse
    output logic [12:0] total, // Samples per line
    output logic [12:0] active, // Active samples per line
    output logic [9:0] py, // Captured luma
    output logic [9:0] pc // Captured chroma
);
    logic [1:0] phase = 2'h0;
    logic prev_blank = 1'b1;
    initial done = 1'b0;
    // A sample is counted at the enabled edge that replaces it
    always @(posedge ref_clk) begin
        done <= 1'b0;
        if (ce) begin
            prev_blank <= h_blank;
        end
        if (arm) begin
            phase <= 2'h1;
        end else if (ce && phase != 2'h0) begin
            if (prev_blank && !h_blank && phase == 2'h2) begin
                phase <= 2'h0;
                done <= 1'b1;
            end else if (prev_blank && !h_blank) begin
                phase <= 2'h2;
                total <= 13'h0001;
                active <= 13'h0001;
                if (probe == 13'h0000) begin
                    py <= y_word;
                    pc <= c_word;
                end
            end else if (phase == 2'h2) begin
                total <= total + 13'h0001;
                if (!h_blank && active == probe) begin
                    py <= y_word;
                    pc <= c_word;
                end
                if (!h_blank) begin
                    active <= active + 13'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/stpg_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module stpg_top_tb import stpg_pkg::*;;
    typedef struct packed {
        logic [12:0] total;
        logic [12:0] active;
        logic [9:0] y;
        logic [9:0] c;
        logic [5:0] flags;
    } stpg_note_s;
    logic ref_clk = 1'b0;
    logic ce = 1'b1;
    logic nrst, dl_en, rate_sel, amp_sel, patho_sel, blank_sel, nocol_sel, seg_sel, arm, done;
    logic [2:0] std_sel;
    logic [3:0] fmt_sel;
    logic [9:0] y_word, c_word, m_y, m_c;
    logic h_blank, v_blank, field_id, sof, frac_rate, seg_frame, dl_active, std_hd, std_3gb, std_3ga;
    logic [10:0] line_num;
    logic [12:0] probe, m_total, m_active;
    stpg_note_s notes[$];
    stpg_note_s cur;
    int num_errors = 0;
    int compares = 0;
    integer seed = 63668;
    // only defined format codes are driven
    logic [3:0] codes [13] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE};
    logic [12:0] ht [13] = '{13'h035A, 13'h0360, 13'h0898, 13'h0A50, 13'h0ABE, 13'h0672, 13'h07BC,
        13'h0CE4, 13'h0F78, 13'h101D, 13'h0898, 13'h0A50, 13'h0ABE};
    logic [12:0] ha [13] = '{13'h02D0, 13'h02D0, 13'h0780, 13'h0780, 13'h0780, 13'h0500, 13'h0500,
        13'h0500, 13'h0500, 13'h0500, 13'h0780, 13'h0780, 13'h0780};
    logic [15:0] frac_mask = 16'h5AD0;
    // Pattern table: {amplitude, colourless, pathological, blank}; 3FF means luma not checked
    logic [3:0] pat [5] = '{4'h8, 4'h0, 4'h4, 4'h2, 4'h3};
    logic [12:0] pr [5] = '{13'h0000, 13'h0000, 13'h005A, 13'h0005, 13'h0005};
    logic [9:0] py [5] = '{10'h3AC, 10'h2D1, 10'h3FF, 10'h198, 10'h040};
    logic [9:0] pc [5] = '{10'h200, 10'h200, 10'h200, 10'h300, 10'h200};

    stpg_top uut (
        .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .std_select(std_sel), .format_select(fmt_sel),
        .dual_link_map_enable(dl_en), .rate_frac_select(rate_sel), .bar_amplitude_select(amp_sel),
        .patho_select(patho_sel), .blank_select(blank_sel), .no_color_select(nocol_sel),
        .seg_frame_select(seg_sel), .y_word(y_word), .c_word(c_word), .h_blank(h_blank),
        .v_blank(v_blank), .field_id(field_id), .sof(sof), .line_num(line_num), .frac_rate(frac_rate),
        .seg_frame(seg_frame), .dl_active(dl_active), .std_hd(std_hd), .std_3gb(std_3gb), .std_3ga(std_3ga)
    );
    stpg_sink sink (
        .ref_clk(ref_clk), .ce(ce), .arm(arm), .probe(probe), .y_word(y_word), .c_word(c_word),
        .h_blank(h_blank), .done(done), .total(m_total), .active(m_active), .py(m_y), .pc(m_c)
    );

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        ce <= ($random(seed) % 16) != 0;
    end

    // ------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------
    task automatic check_hex(input logic [12:0] got, input logic [12:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        if (done && notes.size() != 0) begin
            cur = notes.pop_front();
            check_hex(m_total, cur.total);
            check_hex(m_active, cur.active);
            if (cur.y !== 10'h3FF) begin
                check_hex({3'h0, m_y}, {3'h0, cur.y});
            end
            check_hex({3'h0, m_c}, {3'h0, cur.c});
            check_hex({7'h0, frac_rate, seg_frame, dl_active, std_hd, std_3gb, std_3ga}, {7'h0, cur.flags});
            check_hex({11'h0, v_blank, field_id}, 13'h0000);
        end else if (done) begin
            check_hex(13'h0001, 13'h0000);
        end
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    task automatic measure(input logic [12:0] p, input stpg_note_s n);
        int k;
        probe = p;
        notes.push_back(n);
        arm = 1'b1;
        @(negedge ref_clk);
        arm = 1'b0;
        for (k = 0; k < 20000 && notes.size() != 0; k++) begin
            @(negedge ref_clk);
        end
        if (k == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    initial begin
        nrst = 1'b0;
        std_sel = STD_HD;
        fmt_sel = FMT_525I;
        dl_en = 1'b0;
        rate_sel = 1'b1;
        {amp_sel, nocol_sel, patho_sel, blank_sel, seg_sel, arm} = 6'h00;
        probe = 13'h0000;
        repeat (4) @(negedge ref_clk);
        check_hex({3'h0, y_word}, {3'h0, Y_BLACK});
        check_hex({3'h0, c_word}, {3'h0, C_ZERO});
        // Raster restarts on line 0, which is active, so the first lines are measured directly
        nrst = 1'b1;
        for (int i = 0; i < 5; i++) begin
            {amp_sel, nocol_sel, patho_sel, blank_sel} = pat[i];
            rate_sel = 1'($random(seed));
            @(negedge ref_clk);
            measure(pr[i], '{ht[0], ha[0], py[i], pc[i], 6'h04});
            $display("pattern test %0d done", i);
        end
        {amp_sel, nocol_sel, patho_sel, blank_sel} = 4'h1;
        for (int i = 0; i < 13; i++) begin
            fmt_sel = codes[i];
            std_sel = 3'(i % 3 + 1);
            // dual link only for HD or 3Gb
            dl_en = (std_sel != STD_3GA) ? 1'($random(seed)) : 1'b0;
            rate_sel = 1'($random(seed));
            seg_sel = 1'($random(seed)) | (fmt_sel == FMT_1080I60) | (fmt_sel == FMT_1080I50);
            repeat (8) @(negedge ref_clk);
            measure(13'h0000, '{ht[i], ha[i], Y_BLACK, C_ZERO, {rate_sel & frac_mask[fmt_sel],
                seg_sel & (fmt_sel == FMT_1080I60 || fmt_sel == FMT_1080I50), dl_en,
                std_sel == STD_HD, std_sel == STD_3GB, std_sel == STD_3GA}});
            $display("format test %h done", fmt_sel);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
